// *** aoca_pkg.sv ***
/*
 * Constants, types and timing figures shared by the accelerometer offset
 * cancellation and arming back end.
 * Assumes a 50 MHz system clock; cycle counts derive from that rate.
 */
package aoca_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int RAW_BITS = 20;
  localparam int WORD_BITS = 12;
  localparam int WORD_MSB = 15;
  localparam int WORD_LSB = 4;
  localparam logic [20:0] ROUND_ADD = 21'h00008; // half of the dropped low bits
  localparam int SAMPLE_US = 8;
  localparam int HALF_CYC = CLK_HZ / 1_000_000 * SAMPLE_US / 2;
  localparam int DS_PERIOD_US = 256;
  localparam int DS_CYC = CLK_HZ / 1_000_000 * DS_PERIOD_US;
  localparam int PHASE_SAMPLES = 2048;
  localparam logic [14:0] AVG_START1 = 15'h0030; // 48
  localparam logic [14:0] AVG_START2 = 15'h0180; // 384
  localparam logic [14:0] AVG_START3 = 15'h0C00; // 3072
  localparam logic [14:0] AVG_NORMAL = 15'h6000; // 24576
  localparam int ACC_BITS = 28;
  localparam int MON_BLANK_MS = 2100;
  localparam int MON_BLANK_CYC = CLK_HZ / 1000 * MON_BLANK_MS;
  localparam int HOLDOFF_US = 1000;
  localparam int HOLDOFF_CYC = CLK_HZ / 1_000_000 * HOLDOFF_US;
  localparam int STRETCH_UNIT_CYC = 50_000;
  localparam int CNT_BITS = 28;
  localparam int WIN_DEPTH = 8;
  localparam int WIN_SUM_BITS = 15;
  localparam logic [2:0] ARM_MODE_OFF = 3'h0;
  localparam logic [2:0] ARM_MODE_MAVG = 3'h1;
  typedef enum logic [1:0] {AOCA_START1, AOCA_START2, AOCA_START3, AOCA_NORMAL} aoca_phase_t;
endpackage : aoca_pkg

// *** aoca_core.sv ***
/*
 * Two-axis accelerometer back end: output scaling, 2:1 interpolation, offset
 * cancellation with startup phases, offset monitor, capture of samples on the
 * chip-select rising edge into a two-entry buffer, moving-average arming.
 * Assumes DSP results and SPI request decode arrive on clk_sys; spiCsN is a pin.
 */
`timescale 1ns/100ps
module aoca_core #(
  parameter int DS_CYC = aoca_pkg::DS_CYC,
  parameter int HALF_CYC = aoca_pkg::HALF_CYC,
  parameter int HOLDOFF_CYC = aoca_pkg::HOLDOFF_CYC,
  parameter int MON_BLANK_CYC = aoca_pkg::MON_BLANK_CYC,
  parameter int STRETCH_UNIT_CYC = aoca_pkg::STRETCH_UNIT_CYC,
  parameter int PHASE_SAMPLES = aoca_pkg::PHASE_SAMPLES,
  parameter int BUF_DEPTH = 2,
  parameter int BUF_WIDTH = aoca_pkg::WORD_BITS + 1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic dspValid,
  input wire logic [19:0] dspDataX,
  input wire logic [19:0] dspDataY,
  input wire logic selfTestActive,
  input wire logic initComplete,
  input wire logic phaseOverrideEnable,
  input wire logic [1:0] startupPhaseSelect,
  input wire logic offsetWatchEnable,
  input wire logic [11:0] offsetLimitHigh,
  input wire logic [11:0] offsetLimitLow,
  input wire logic offsetCancelDisableNCfg,
  input wire logic spiCsN,
  input wire logic reqAccel,
  input wire logic reqAxisY,
  input wire logic reqCancelDisableN,
  input wire logic [2:0] armingMode,
  input wire logic [1:0] windowSizeX,
  input wire logic [1:0] windowSizeY,
  input wire logic [7:0] armingThresholdPosX,
  input wire logic [7:0] armingThresholdNegX,
  input wire logic [7:0] armingThresholdPosY,
  input wire logic [7:0] armingThresholdNegY,
  input wire logic [1:0] stretchLengthX,
  input wire logic [1:0] stretchLengthY,
  input wire logic deviceError,
  input wire logic respReady,
  output logic captureReady,
  output logic respValid,
  output logic [11:0] respData,
  output logic respAxisY,
  output logic offsetOverRangeX,
  output logic offsetOverRangeY,
  output logic armX,
  output logic armY
);
  localparam int W = aoca_pkg::WORD_BITS;
  localparam int R = aoca_pkg::RAW_BITS;
  localparam int A = aoca_pkg::ACC_BITS;
  localparam int C = aoca_pkg::CNT_BITS;
  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int INTERP_SPAN = HALF_CYC + 1; // last cycle at which the clipped word may appear

  // clip the top bits and round the low ones into a 12-bit word
  function automatic logic [W-1:0] aoca_scale(input logic [R-1:0] r);
    logic [R:0] w;
    logic ovf;
    w = {r[R-1], r} + aoca_pkg::ROUND_ADD;
    ovf = (w[R:aoca_pkg::WORD_MSB] != {(R + 1 - aoca_pkg::WORD_MSB){w[R]}});
    return ovf ? {w[R], {(W - 1){~w[R]}}} : w[aoca_pkg::WORD_MSB:aoca_pkg::WORD_LSB];
  endfunction : aoca_scale

  // saturate a 13-bit difference back to the word width
  function automatic logic [W-1:0] aoca_sat(input logic [W:0] v);
    return (v[W] != v[W-1]) ? {v[W], {(W - 1){~v[W]}}} : v[W-1:0];
  endfunction : aoca_sat

  // samples averaged in each offset cancellation phase
  function automatic logic [14:0] aoca_avg_n(input aoca_pkg::aoca_phase_t p);
    unique case (p)
      aoca_pkg::AOCA_START1: return aoca_pkg::AVG_START1;
      aoca_pkg::AOCA_START2: return aoca_pkg::AVG_START2;
      aoca_pkg::AOCA_START3: return aoca_pkg::AVG_START3;
      aoca_pkg::AOCA_NORMAL: return aoca_pkg::AVG_NORMAL;
    endcase
  endfunction : aoca_avg_n

  // mean of the newest 2**ws history entries
  function automatic logic [W-1:0] aoca_win_avg(input logic [aoca_pkg::WIN_DEPTH-1:0][W-1:0] h,
                                                input logic [1:0] ws);
    logic signed [aoca_pkg::WIN_SUM_BITS-1:0] s;
    s = '0;
    for (int i = 0; i < aoca_pkg::WIN_DEPTH; i++) begin
      if (i < (1 << ws)) s = s + aoca_pkg::WIN_SUM_BITS'($signed(h[i]));
    end
    return W'(s >>> ws);
  endfunction : aoca_win_avg

  // chip-select pin synchroniser and rising edge
  logic csMeta, csSync, csPrev;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) {csMeta, csSync, csPrev} <= 3'h7;
    else {csMeta, csSync, csPrev} <= {spiCsN, csMeta, csSync};
  end
  wire csRise = csSync && !csPrev;
  wire capEvt = csRise && reqAccel;
  wire ocOn = !offsetCancelDisableNCfg && !reqCancelDisableN;

  // shared timebase: downsample tick, phase, self-test holdoff, monitor blanking
  aoca_pkg::aoca_phase_t phase;
  logic [$clog2(DS_CYC)-1:0] dsCnt;
  logic [$clog2(PHASE_SAMPLES)-1:0] phaseCnt;
  logic [$clog2(HOLDOFF_CYC+1)-1:0] holdCnt;
  logic [$clog2(MON_BLANK_CYC+1)-1:0] blankCnt;
  wire dsTick = (dsCnt == '0);
  wire suspend = selfTestActive || (holdCnt != '0);
  wire forcePhase = !initComplete && phaseOverrideEnable;
  wire phaseEnd = dsTick && !suspend && (phaseCnt == PHASE_SAMPLES - 1);
  wire [14:0] avgN = aoca_avg_n(phase);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dsCnt <= '0;
      phase <= aoca_pkg::AOCA_START1;
      phaseCnt <= '0;
      holdCnt <= '0;
      blankCnt <= $bits(blankCnt)'(MON_BLANK_CYC);
    end else begin
      dsCnt <= dsTick ? $bits(dsCnt)'(DS_CYC - 1) : dsCnt - 1'b1;
      if (forcePhase) phase <= aoca_pkg::aoca_phase_t'(startupPhaseSelect);
      else if (phaseEnd && phase != aoca_pkg::AOCA_NORMAL) phase <= aoca_pkg::aoca_phase_t'(phase + 2'h1);
      if (dsTick && !suspend) phaseCnt <= phaseCnt + 1'b1;
      if (selfTestActive) holdCnt <= $bits(holdCnt)'(HOLDOFF_CYC);
      else if (holdCnt != '0) holdCnt <= holdCnt - 1'b1;
      if (blankCnt != '0) blankCnt <= blankCnt - 1'b1;
    end
  end

  logic [W-1:0] interp [2];
  logic [W-1:0] canc [2];
  logic [W-1:0] corr [2];
  logic oor [2];
  logic armOut [2];
  logic [C-1:0] strCnt [2];
  logic evalPend [2];
  logic [2:0] modePrev;
  wire armMavg = (armingMode == aoca_pkg::ARM_MODE_MAVG);
  wire modeChg = (armingMode != modePrev);
  wire [R-1:0] raw [2];
  wire [1:0] winSize [2];
  wire [7:0] thrPos [2];
  wire [7:0] thrNeg [2];
  wire [1:0] strLen [2];
  assign raw[0] = dspDataX;
  assign raw[1] = dspDataY;
  assign winSize[0] = windowSizeX;
  assign winSize[1] = windowSizeY;
  assign thrPos[0] = armingThresholdPosX;
  assign thrPos[1] = armingThresholdPosY;
  assign thrNeg[0] = armingThresholdNegX;
  assign thrNeg[1] = armingThresholdNegY;
  assign strLen[0] = stretchLengthX;
  assign strLen[1] = stretchLengthY;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) modePrev <= aoca_pkg::ARM_MODE_OFF;
    else modePrev <= armingMode;
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gAxis
      // scaling and half-sample delayed interpolation
      logic [W-1:0] last, pend;
      wire [W-1:0] scaled = aoca_scale(raw[g]);
      wire [W:0] pairSum = {last[W-1], last} + {scaled[W-1], scaled};
      logic [$clog2(HALF_CYC+1)-1:0] halfCnt;
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          {last, pend, interp[g]} <= '0;
          halfCnt <= '0;
        end else if (dspValid) begin
          last <= scaled;
          pend <= scaled;
          interp[g] <= pairSum[W:1];
          halfCnt <= $bits(halfCnt)'(HALF_CYC);
        end else if (halfCnt != '0) begin
          halfCnt <= halfCnt - 1'b1;
          if (halfCnt == 1) interp[g] <= pend;
        end
      end

      // offset cancellation accumulator and correction steps
      logic signed [A-1:0] acc;
      logic [14:0] accCnt;
      wire [W:0] diff = {interp[g][W-1], interp[g]} - {corr[g][W-1], corr[g]};
      assign canc[g] = aoca_sat(diff);
      wire signed [A-1:0] accNext = acc + A'($signed(canc[g]));
      wire signed [A-1:0] halfN = A'(avgN >> 1);
      wire blockEnd = dsTick && !suspend && (accCnt >= avgN - 15'h0001);
      wire [W-1:0] corrNext = !blockEnd ? corr[g] :
                              (accNext >= halfN) ? corr[g] + 1'b1 :
                              (accNext <= -halfN) ? corr[g] - 1'b1 : corr[g];
      wire overLimit = ($signed(corrNext) > $signed(offsetLimitHigh)) ||
                       ($signed(corrNext) < $signed(offsetLimitLow));
      wire monOff = !offsetWatchEnable || (blankCnt != '0);
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          acc <= '0;
          accCnt <= '0;
          corr[g] <= '0;
          oor[g] <= 1'b0;
        end else begin
          if (dsTick && !suspend) begin
            acc <= blockEnd ? '0 : accNext;
            accCnt <= blockEnd ? '0 : accCnt + 1'b1;
          end
          corr[g] <= corrNext;
          oor[g] <= monOff ? 1'b0 : (blockEnd ? overLimit : oor[g]);
        end
      end

      // moving-average arming with pulse stretch
      logic [aoca_pkg::WIN_DEPTH-1:0][W-1:0] hist;
      logic armCond;
      wire sampleEvt = capEvt && (reqAxisY == g) && armMavg && !deviceError;
      wire [W-1:0] winAvg = aoca_win_avg(hist, winSize[g]);
      wire hitPos = $signed({winAvg[W-1], winAvg}) >= $signed({5'h00, thrPos[g]});
      wire hitNeg = $signed({winAvg[W-1], winAvg}) <= -$signed({5'h00, thrNeg[g]});
      wire condNext = evalPend[g] ? (hitPos || hitNeg) : armCond;
      wire reload = evalPend[g] && (hitPos || hitNeg) && (strLen[g] != 2'h0);
      wire [C-1:0] cntNext = reload ? C'(strLen[g] * STRETCH_UNIT_CYC) :
                             (strCnt[g] != '0) ? strCnt[g] - 1'b1 : strCnt[g];
      wire outNext = armMavg && ((strLen[g] == 2'h0) ? condNext : (cntNext != '0));
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          hist <= '0;
          evalPend[g] <= 1'b0;
          armCond <= 1'b0;
          strCnt[g] <= '0;
          armOut[g] <= 1'b0;
        end else begin
          if (modeChg) hist <= '0;
          else if (sampleEvt) hist <= {hist[aoca_pkg::WIN_DEPTH-2:0], canc[g]};
          evalPend[g] <= sampleEvt && !modeChg;
          armCond <= modeChg ? 1'b0 : condNext;
          strCnt[g] <= cntNext;
          armOut[g] <= outNext;
        end
      end
    end
  endgenerate
  assign offsetOverRangeX = oor[0];
  assign offsetOverRangeY = oor[1];
  assign armX = armOut[0];
  assign armY = armOut[1];

  // two-entry capture buffer between chip-select latch and SPI shifter
  logic [BUF_WIDTH-1:0] mem [BUF_DEPTH];
  logic [PW-1:0] wp, rp;
  logic [PW:0] fill;
  wire full = (fill == (PW + 1)'(BUF_DEPTH));
  wire push = capEvt && !full;
  wire pop = respValid && respReady;
  wire [W-1:0] capWord = ocOn ? canc[reqAxisY] : interp[reqAxisY];
  assign captureReady = !full;
  assign respValid = (fill != '0);
  assign {respAxisY, respData} = mem[rp];
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wp <= '0;
      rp <= '0;
      fill <= '0;
      for (int i = 0; i < BUF_DEPTH; i++) mem[i] <= '0;
    end else begin
      if (push) mem[wp] <= BUF_WIDTH'({reqAxisY, capWord});
      if (push) wp <= (wp == PW'(BUF_DEPTH - 1)) ? '0 : wp + 1'b1;
      if (pop) rp <= (rp == PW'(BUF_DEPTH - 1)) ? '0 : rp + 1'b1;
      fill <= fill + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end

  // checks on the guarded behaviour
  chk_corr_frozen: assert property (@(posedge clk_sys) disable iff (!resetn)
    selfTestActive |=> $stable(corr[0])) else $error("correction moved during self test");
  chk_holdoff_after: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(selfTestActive) |-> suspend [*8]) else $error("cancellation resumed too soon");
  chk_monitor_gated: assert property (@(posedge clk_sys) disable iff (!resetn)
    !offsetWatchEnable |=> !offsetOverRangeX && !offsetOverRangeY) else $error("monitor ran while disabled");
  chk_monitor_blank: assert property (@(posedge clk_sys) disable iff (!resetn)
    blankCnt != '0 |=> !offsetOverRangeX) else $error("monitor active during blanking");
  chk_scale_clip: assert property (@(posedge clk_sys) disable iff (!resetn)
    dspValid && !raw[0][R-1] && raw[0][R-2] |-> ##[1:INTERP_SPAN] interp[0] == {1'b0, {(W - 1){1'b1}}})
    else $error("over-range result not clipped");
  chk_capture_held: assert property (@(posedge clk_sys) disable iff (!resetn)
    push |=> respValid) else $error("captured sample not offered");
  chk_direct_arm: assert property (@(posedge clk_sys) disable iff (!resetn)
    evalPend[0] && armMavg && stretchLengthX == 2'h0 && !modeChg |=> armX == $past(gAxis[0].condNext))
    else $error("direct arming output wrong");
  chk_stretch_count: assert property (@(posedge clk_sys) disable iff (!resetn)
    strCnt[0] > 1 && !gAxis[0].reload |=> strCnt[0] == $past(strCnt[0]) - 1'b1) else $error("stretch not counting");
  chk_error_freeze: assert property (@(posedge clk_sys) disable iff (!resetn)
    deviceError |=> !evalPend[0] && !evalPend[1]) else $error("arming updated after error");
  cover_capture_full: cover property (@(posedge clk_sys) disable iff (!resetn) capEvt && full);
  cover_arm_stretch: cover property (@(posedge clk_sys) disable iff (!resetn) gAxis[0].reload ##1 armX);
  cover_phase_normal: cover property (@(posedge clk_sys) disable iff (!resetn) phase == aoca_pkg::AOCA_NORMAL);
  cover_over_range: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(offsetOverRangeY));
endmodule : aoca_core

// *** aoca_spi_host.sv ***
/*
 * Behavioural SPI master that issues acceleration requests to the back end.
 * Assumes the back end samples spiCsN and the decoded request lines on clk_sys.
 */
`timescale 1ns/100ps
module aoca_spi_host (
  input wire logic clk_sys,
  output logic spiCsN,
  output logic reqAccel,
  output logic reqAxisY,
  output logic reqCancelDisableN
);
  localparam int LINK_CYC = 8; // one 160 ns link period
  // idle: deselected, no request pending
  initial begin
    spiCsN = 1'b1;
    reqAccel = 1'b0;
    reqAxisY = 1'b0;
    reqCancelDisableN = 1'b1;
  end
  // one request frame; the fields stand until the rise has been synchronised
  task automatic xfer(input logic axisY, input logic cdn, input int lowCyc);
    @(posedge clk_sys);
    #1;
    spiCsN = 1'b0;
    reqAccel = 1'b1;
    reqAxisY = axisY;
    reqCancelDisableN = cdn;
    repeat (lowCyc) @(posedge clk_sys);
    #1;
    spiCsN = 1'b1; // rise ends the request
    repeat (4) @(posedge clk_sys);
    #1;
    reqAccel = 1'b0;
    reqAxisY = ~axisY; // released lines drop the last value
    reqCancelDisableN = ~cdn;
    repeat (LINK_CYC) @(posedge clk_sys); // spacing between requests
    #1; // hand back off the edge so the caller never drives in the sampling step
  endtask : xfer
endmodule : aoca_spi_host

// *** tb_top.sv ***
/*
 * Self-checking bench: scaling, interpolation, capture buffer, arming, monitor.
 * Assumes aoca_pkg, aoca_core and aoca_spi_host are compiled before it.
 */
`timescale 1ns/100ps
module tb_top;
  logic clk_sys, resetn, dspValid, selfTestActive, initComplete, phaseOverrideEnable, offsetWatchEnable;
  logic offsetCancelDisableNCfg, spiCsN, reqAccel, reqAxisY, reqCancelDisableN, deviceError, respReady;
  logic captureReady, respValid, respAxisY, offsetOverRangeX, offsetOverRangeY, armX, armY;
  logic [19:0] dspDataX, dspDataY;
  logic [11:0] offsetLimitHigh, offsetLimitLow, respData;
  logic [7:0] armingThresholdPosX, armingThresholdNegX, armingThresholdPosY, armingThresholdNegY;
  logic [2:0] armingMode;
  logic [1:0] startupPhaseSelect, windowSizeX, windowSizeY, stretchLengthX, stretchLengthY;
  logic [31:0] seed;
  int failCount, totalChecks, cyc;

  // design with shortened counts, partner on the request side
  aoca_core #(.DS_CYC(4), .HALF_CYC(8), .HOLDOFF_CYC(8), .MON_BLANK_CYC(20), .STRETCH_UNIT_CYC(40),
    .PHASE_SAMPLES(16)) dut (.clk_sys, .resetn, .dspValid, .dspDataX, .dspDataY, .selfTestActive,
    .initComplete, .phaseOverrideEnable, .startupPhaseSelect, .offsetWatchEnable, .offsetLimitHigh,
    .offsetLimitLow, .offsetCancelDisableNCfg, .spiCsN, .reqAccel, .reqAxisY, .reqCancelDisableN,
    .armingMode, .windowSizeX, .windowSizeY, .armingThresholdPosX, .armingThresholdNegX,
    .armingThresholdPosY, .armingThresholdNegY, .stretchLengthX, .stretchLengthY, .deviceError,
    .respReady, .captureReady, .respValid, .respData, .respAxisY, .offsetOverRangeX,
    .offsetOverRangeY, .armX, .armY);
  aoca_spi_host host (.clk_sys, .spiCsN, .reqAccel, .reqAxisY, .reqCancelDisableN);

  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // repeatable random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // expected word: round at bit 3, keep bits 15..4, saturate when out of range
  function automatic logic [11:0] scl(input logic [19:0] v);
    logic signed [20:0] r;
    r = $signed({v[19], v}) + 21'sh00008;
    if (r > 21'sh07FFF) return 12'h7FF;
    if (r < -21'sh08000) return 12'h800;
    return r[15:4];
  endfunction : scl

  // comparisons for words and for flags
  task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk12
  task automatic chk1(input logic got, input logic exp);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk1

  // one data-path result, spaced beyond the half-sample delay
  task automatic put(input logic [19:0] x, input logic [19:0] y);
    @(posedge clk_sys);
    #1;
    dspValid = 1'b1;
    dspDataX = x;
    dspDataY = y;
    @(posedge clk_sys);
    #1;
    dspValid = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
  endtask : put
  task automatic put2(input logic [19:0] x, input logic [19:0] y);
    put(x, y);
    put(x, y);
  endtask : put2
  // wait for the head word, compare it, then pop it
  task automatic pop(input logic ay, input logic [11:0] exp);
    int n;
    n = 0;
    while (respValid !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk1(respValid, 1'b1);
    chk12(respData, exp);
    chk1(respAxisY, ay);
    respReady = 1'b1;
    @(posedge clk_sys);
    #1;
    respReady = 1'b0;
  endtask : pop
  task automatic cap(input logic ay, input logic cdn, input logic [11:0] exp);
    host.xfer(ay, cdn, 8);
    pop(ay, exp);
  endtask : cap
  // one arming sample of a 12-bit word, then the arming output that follows
  task automatic arm(input logic ay, input logic [11:0] w, input logic exp);
    put2({{4{w[11]}}, w, 4'h0}, {{4{w[11]}}, w, 4'h0});
    cap(ay, 1'b0, w);
    repeat (4) @(posedge clk_sys);
    #1;
    chk1(ay ? armY : armX, exp);
  endtask : arm

  // counts and verdict
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : printVerdict

  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 12000) begin
      failCount++;
      printVerdict();
    end
  end

  // main sequence
  initial begin
    logic [19:0] v, w;
    logic [19:0] corner [4];
    corner = '{20'h07FF8, 20'h80000, 20'h07FF7, 20'hFFFF7};
    {dspValid, deviceError, respReady, offsetWatchEnable, offsetCancelDisableNCfg, initComplete, resetn} = 7'h00;
    {selfTestActive, phaseOverrideEnable} = 2'h3; // forced first phase while init open
    {windowSizeX, windowSizeY, stretchLengthX, stretchLengthY, startupPhaseSelect} = 10'h000;
    {armingThresholdPosX, armingThresholdNegX, armingThresholdPosY, armingThresholdNegY} = 32'h64646464;
    dspDataX = 20'h00000;
    dspDataY = 20'h00000;
    armingMode = aoca_pkg::ARM_MODE_OFF;
    offsetLimitHigh = 12'h000;
    offsetLimitLow = 12'h800;
    seed = 32'h5E610EE1;
    repeat (3) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    // scaling: corners, then random results on both axes
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      v = (i < 4) ? corner[i] : seed[19:0];
      seed = xs(seed);
      w = seed[19:0];
      put2(v, w);
      cap(1'b0, 1'b1, scl(v));
      cap(1'b1, 1'b1, scl(w));
    end
    $display("test scaling done");
    // capture lands while the averaged value stands
    put2(20'h00400, 20'h00400);
    fork
      host.xfer(1'b0, 1'b1, 16);
      begin
        repeat (14) @(posedge clk_sys);
        put(20'h00800, 20'h00800);
      end
    join
    pop(1'b0, 12'h060);
    cap(1'b0, 1'b1, 12'h080);
    $display("test interpolation done");
    // reader stalls: two words fill the buffer, the third request is dropped
    host.xfer(1'b0, 1'b1, 8);
    put2(20'h00C00, 20'h00C00);
    host.xfer(1'b1, 1'b1, 8);
    chk1(captureReady, 1'b0);
    host.xfer(1'b0, 1'b1, 8);
    pop(1'b0, 12'h080);
    pop(1'b1, 12'h0C0);
    chk1(respValid, 1'b0);
    $display("test buffer done");
    // moving-average arming: equality, direct output, error freeze, stretch
    armingMode = aoca_pkg::ARM_MODE_MAVG;
    arm(1'b0, 12'h064, 1'b1);
    arm(1'b0, 12'h063, 1'b0);
    deviceError = 1'b1;
    arm(1'b0, 12'h064, 1'b0);
    deviceError = 1'b0;
    arm(1'b0, 12'h064, 1'b1);
    stretchLengthX = 2'h3;
    arm(1'b0, 12'h064, 1'b1);
    arm(1'b0, 12'h063, 1'b1);
    repeat (80) @(posedge clk_sys);
    #1;
    chk1(armX, 1'b0);
    // window change with arming off, history cleared on mode change
    stretchLengthX = 2'h0;
    armingMode = aoca_pkg::ARM_MODE_OFF;
    repeat (2) @(posedge clk_sys);
    #1;
    windowSizeX = 2'h1;
    windowSizeY = 2'h1;
    stretchLengthY = 2'h1;
    armingMode = aoca_pkg::ARM_MODE_MAVG;
    arm(1'b0, 12'h064, 1'b0);
    arm(1'b0, 12'h062, 1'b0);
    arm(1'b0, 12'h064, 1'b0);
    arm(1'b0, 12'h064, 1'b1);
    arm(1'b1, 12'hF9C, 1'b0);
    arm(1'b1, 12'hF9C, 1'b1);
    arm(1'b1, 12'hF9E, 1'b0);
    $display("test arming done");
    // monitor: positive offset pushes the correction past the high limit
    armingMode = aoca_pkg::ARM_MODE_OFF;
    selfTestActive = 1'b0;
    offsetWatchEnable = 1'b1;
    for (int i = 0; i < 200 && offsetOverRangeX !== 1'b1; i++) put(20'h00640, 20'h00640);
    chk1(offsetOverRangeX, 1'b1);
    chk1(offsetOverRangeY, 1'b1);
    cap(1'b0, 1'b0, 12'h063);
    cap(1'b0, 1'b1, 12'h064);
    offsetCancelDisableNCfg = 1'b1;
    cap(1'b0, 1'b0, 12'h064);
    offsetWatchEnable = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    chk1(offsetOverRangeX, 1'b0);
    // forced normal phase: its block is far longer than the wait, so the correction holds
    offsetCancelDisableNCfg = 1'b0;
    startupPhaseSelect = 2'h3;
    repeat (250) @(posedge clk_sys);
    #1;
    cap(1'b0, 1'b0, 12'h063);
    // once init is complete the override is ignored and the phase stays normal
    initComplete = 1'b1;
    startupPhaseSelect = 2'h0;
    repeat (250) @(posedge clk_sys);
    #1;
    cap(1'b0, 1'b0, 12'h063);
    $display("test monitor done");
    printVerdict();
  end
endmodule : tb_top
